// ### adcs_core_model.sv
// Behavioural converter core facing the sequencer
`timescale 1ns/1ns
module adcs_core_model (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // From the sequencer
  input wire [3:0] i_mux_chan,
  input wire i_convert,
  // Result lines
  output logic [9:0] o_result
);
  logic [2:0] hold;
  logic [9:0] last;
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold <= 3'h0;
      last <= 10'h000;
    end else if (i_convert) begin
      hold <= 3'h4;
      last <= {i_mux_chan, 6'h15};
    end else if (hold != 3'h0) begin
      hold <= hold - 3'h1;
    end
  end
  // Lines are not held once the result has been taken
  assign o_result = (i_convert || hold != 3'h0) ? last : ~last;
endmodule // adcs_core_model

// ### adcs_regs.vh
// Register map, field positions and timing counts of the ADC sequencer
`ifndef ADCS_REGS_VH
`define ADCS_REGS_VH

// Byte offsets on the AHB-Lite bus (address bits 7:2 decoded)
`define ADCS_OFF_CTRL 8'h00
`define ADCS_OFF_RESULT 8'h04
`define ADCS_OFF_INJ 8'h08
`define ADCS_OFF_STATUS 8'h0C
`define ADCS_OFF_DIGIN 8'h14

// converter_control_reg fields
`define ADCS_CTRL_CHAN_LSB 0
`define ADCS_CTRL_MODE_LSB 4
`define ADCS_CTRL_START_BIT 6
`define ADCS_CTRL_BUSY_BIT 7
`define ADCS_CTRL_WFR_BIT 8
`define ADCS_CTRL_INJ_BIT 9
`define ADCS_CTRL_SSEL_LSB 10
`define ADCS_CTRL_CSEL_LSB 12
`define ADCS_CTRL_INJCH_LSB 16

// Result registers: value in [9:0], channel in [15:12], valid in [16]
`define ADCS_RES_CHAN_LSB 12
`define ADCS_RES_VALID_BIT 16

// Status register fields
`define ADCS_STAT_OVR_BIT 0
`define ADCS_STAT_EMPTY_BIT 1
`define ADCS_STAT_FULL_BIT 2
`define ADCS_STAT_BUSY_BIT 3
`define ADCS_STAT_RUN_BIT 4
`define ADCS_STAT_CNT_LSB 8

// Operating modes
`define ADCS_MODE_SINGLE 2'b00
`define ADCS_MODE_CONT 2'b01
`define ADCS_MODE_SCAN 2'b10
`define ADCS_MODE_SCANC 2'b11

// Reset values
`define ADCS_CTRL_RESET 32'h00000000
`define ADCS_HRDATA_RESET 32'h00000000

// Timing: clock cycles per base clock phase and phase counts
`define ADCS_PHASE_CYCLES 12'h001
`define ADCS_PH_24 12'h018
`define ADCS_PH_48 12'h030
`define ADCS_PH_96 12'h060
// Conversion clock periods per conversion
`define ADCS_CONV_TCC 12'h00A

`endif

// ### adcs_top.v
// ADC conversion sequencer with AHB-Lite registers and result FIFO
// What this block does
// - Selects one of 16 inputs through the mux and yields a 10-bit result.
// - With overrun signalling, a full buffer at completion raises overrun.
// - Alternatively, the next conversion is held until results are read.
// - All analog input pins can be read by software as digital inputs.
// - Single-channel single mode converts the chosen channel exactly once.
// - Single-channel continuous mode converts the channel until stopped.
// - Auto-scan single converts each channel from the chosen one down to 0 once, storing each result.
// - Auto-scan continuous repeats the scan without end, storing each result.
// - Every conversion stored in the result buffer issues a request for software or transfer unit.
// - With wait-for-read set, conversion pauses while the result buffer is full, until a result is read.
// - An injected channel converts in between into the injection register.
// - After an injection the running continuous mode resumes unchanged.
// - Conversion clock codes 00/10/11 give 24/96/48 base phases.
// - Sample clock codes 00/01/10/11 give 1/2/4/8 conversion clocks.
//
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`include "adcs_regs.vh"

module adcs_fifo #(
  parameter WIDTH = 14,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Fill side
  input wire i_wr_valid,
  output wire o_wr_ready,
  input wire [WIDTH-1:0] i_wr_data,
  // Drain side
  output wire o_rd_valid,
  input wire i_rd_ready,
  output wire [WIDTH-1:0] o_rd_data,
  output wire [AW:0] o_count
);
  localparam [AW:0] FULL_CNT = DEPTH[AW:0];
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wp;
  reg [AW:0] rp;
  wire push;
  wire pop;
  assign o_count = wp - rp;
  assign o_wr_ready = (o_count != FULL_CNT);
  assign o_rd_valid = (o_count != {(AW+1){1'b0}});
  assign o_rd_data = mem[rp[AW-1:0]];
  assign push = i_wr_valid & o_wr_ready;
  assign pop = o_rd_valid & i_rd_ready;
  always @(posedge i_clk) begin
    if (push) begin
      mem[wp[AW-1:0]] <= i_wr_data;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wp <= {(AW+1){1'b0}};
      rp <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp <= wp + {{AW{1'b0}}, 1'b1};
      end
      if (pop) begin
        rp <= rp + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // adcs_fifo

module adcs_top (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // AHB-Lite slave
  input wire i_hsel,
  input wire [31:0] i_haddr,
  input wire [1:0] i_htrans,
  input wire i_hwrite,
  input wire [2:0] i_hsize,
  input wire [31:0] i_hwdata,
  input wire i_hready,
  output reg o_hreadyout,
  output reg o_hresp,
  output reg [31:0] o_hrdata,
  // Converter core side
  output reg [3:0] o_mux_chan,
  output reg o_sample,
  output reg o_convert,
  input wire [9:0] i_core_result,
  // Analog pins read as digital levels
  input wire [15:0] i_ain_digital,
  // Status and service requests
  output reg o_busy,
  output reg o_result_req,
  output reg o_overrun_req
);
  localparam ST_IDLE = 2'b00;
  localparam ST_SAMPLE = 2'b01;
  localparam ST_CONVERT = 2'b10;
  localparam ST_STORE = 2'b11;
  // Conversion clock length in i_clk cycles
  function [11:0] adcs_tcc;
    input [1:0] sel;
    begin
      case (sel)
        2'b10: adcs_tcc = `ADCS_PH_96 * `ADCS_PHASE_CYCLES;
        2'b11: adcs_tcc = `ADCS_PH_48 * `ADCS_PHASE_CYCLES;
        default: adcs_tcc = `ADCS_PH_24 * `ADCS_PHASE_CYCLES;
      endcase
    end
  endfunction
  // Bus state
  reg pend;
  reg pend_write;
  reg [7:0] pend_addr;
  // Control fields
  reg [3:0] ctl_chan;
  reg [1:0] ctl_mode;
  reg wfr;
  reg [1:0] ssel;
  reg [1:0] csel;
  reg [3:0] inj_chan;
  reg run;
  reg inj_pend;
  // Sequencer
  reg [1:0] state;
  reg [11:0] cnt;
  reg [3:0] cur_chan;
  reg is_inj;
  reg [9:0] conv_val;
  reg [9:0] inj_res;
  reg [3:0] inj_res_ch;
  reg inj_valid;
  reg overrun;
  // Pin synchronisers
  reg [9:0] core_s1;
  reg [9:0] core_s2;
  reg [15:0] din_s1;
  reg [15:0] din_s2;
  wire [11:0] tcc_cyc;
  wire [11:0] tsc_cyc;
  wire [11:0] conv_cyc;
  wire fifo_wr_valid;
  wire fifo_wr_ready;
  wire fifo_rd_valid;
  wire fifo_rd_ready;
  wire [13:0] fifo_rd_data;
  wire [4:0] fifo_count;
  wire rd_cycle;
  wire wr_cycle;
  wire ovr_evt;
  wire inj_done;
  wire ovr_clr;
  wire inj_go;
  reg [31:0] rd_mux;
  assign tcc_cyc = adcs_tcc(csel);
  assign tsc_cyc = tcc_cyc << ssel;
  assign conv_cyc = tcc_cyc * `ADCS_CONV_TCC;
  assign rd_cycle = pend & ~pend_write;
  assign wr_cycle = pend & pend_write;
  assign fifo_wr_valid = (state == ST_STORE) & ~is_inj;
  assign ovr_evt = fifo_wr_valid & ~fifo_wr_ready;
  assign inj_done = (state == ST_STORE) & is_inj;
  assign inj_go = inj_pend & ctl_mode[0];
  assign fifo_rd_ready = rd_cycle & (pend_addr == `ADCS_OFF_RESULT);
  assign ovr_clr = wr_cycle & (pend_addr == `ADCS_OFF_STATUS) &
                   i_hwdata[`ADCS_STAT_OVR_BIT];
  adcs_fifo #(
    .WIDTH(14),
    .DEPTH(16),
    .AW(4)
  ) u_adcs_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_wr_valid(fifo_wr_valid),
    .o_wr_ready(fifo_wr_ready),
    .i_wr_data({o_mux_chan, conv_val}),
    .o_rd_valid(fifo_rd_valid),
    .i_rd_ready(fifo_rd_ready),
    .o_rd_data(fifo_rd_data),
    .o_count(fifo_count)
  );
  // Two-stage synchronisers for pin inputs
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      core_s1 <= 10'h000;
      core_s2 <= 10'h000;
      din_s1 <= 16'h0000;
      din_s2 <= 16'h0000;
    end else begin
      core_s1 <= i_core_result;
      core_s2 <= core_s1;
      din_s1 <= i_ain_digital;
      din_s2 <= din_s1;
    end
  end
  // Read data selection
  always @* begin
    rd_mux = 32'h00000000;
    case (pend_addr)
      `ADCS_OFF_CTRL: begin
        rd_mux[`ADCS_CTRL_CHAN_LSB +: 4] = ctl_chan;
        rd_mux[`ADCS_CTRL_MODE_LSB +: 2] = ctl_mode;
        rd_mux[`ADCS_CTRL_START_BIT] = run;
        rd_mux[`ADCS_CTRL_BUSY_BIT] = o_busy;
        rd_mux[`ADCS_CTRL_WFR_BIT] = wfr;
        rd_mux[`ADCS_CTRL_INJ_BIT] = inj_pend;
        rd_mux[`ADCS_CTRL_SSEL_LSB +: 2] = ssel;
        rd_mux[`ADCS_CTRL_CSEL_LSB +: 2] = csel;
        rd_mux[`ADCS_CTRL_INJCH_LSB +: 4] = inj_chan;
      end
      `ADCS_OFF_RESULT: begin
        rd_mux[9:0] = fifo_rd_data[9:0];
        rd_mux[`ADCS_RES_CHAN_LSB +: 4] = fifo_rd_data[13:10];
        rd_mux[`ADCS_RES_VALID_BIT] = fifo_rd_valid;
      end
      `ADCS_OFF_INJ: begin
        rd_mux[9:0] = inj_res;
        rd_mux[`ADCS_RES_CHAN_LSB +: 4] = inj_res_ch;
        rd_mux[`ADCS_RES_VALID_BIT] = inj_valid;
      end
      `ADCS_OFF_STATUS: begin
        rd_mux[`ADCS_STAT_OVR_BIT] = overrun;
        rd_mux[`ADCS_STAT_EMPTY_BIT] = ~fifo_rd_valid;
        rd_mux[`ADCS_STAT_FULL_BIT] = ~fifo_wr_ready;
        rd_mux[`ADCS_STAT_BUSY_BIT] = o_busy;
        rd_mux[`ADCS_STAT_RUN_BIT] = run;
        rd_mux[`ADCS_STAT_CNT_LSB +: 5] = fifo_count;
      end
      `ADCS_OFF_DIGIN: rd_mux[15:0] = din_s2;
      default: rd_mux = 32'h00000000;
    endcase
  end
  // Bus slave: one wait state, data phase acts in the pending cycle
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pend <= 1'b0;
      pend_write <= 1'b0;
      pend_addr <= 8'h00;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
      o_hrdata <= `ADCS_HRDATA_RESET;
    end else begin
      o_hresp <= 1'b0;
      if (pend) begin
        pend <= 1'b0;
        o_hreadyout <= 1'b1;
        if (!pend_write) begin
          o_hrdata <= rd_mux;
        end
      end else if (i_hsel && i_htrans[1] && i_hready) begin
        pend <= 1'b1;
        pend_write <= i_hwrite;
        pend_addr <= {i_haddr[7:2], 2'b00};
        o_hreadyout <= 1'b0;
      end
    end
  end
  // Sticky flags: a set in the clearing cycle wins
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      overrun <= 1'b0;
      inj_valid <= 1'b0;
      o_overrun_req <= 1'b0;
    end else begin
      o_overrun_req <= ovr_evt & ~wfr;
      overrun <= ovr_evt | (overrun & ~ovr_clr);
      inj_valid <= inj_done |
                   (inj_valid & ~(rd_cycle & (pend_addr == `ADCS_OFF_INJ)));
    end
  end
  // Sequencer and control register
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_chan <= 4'h0;
      ctl_mode <= `ADCS_MODE_SINGLE;
      wfr <= 1'b0;
      ssel <= 2'b00;
      csel <= 2'b00;
      inj_chan <= 4'h0;
      run <= 1'b0;
      inj_pend <= 1'b0;
      state <= ST_IDLE;
      cnt <= 12'h000;
      cur_chan <= 4'h0;
      is_inj <= 1'b0;
      conv_val <= 10'h000;
      inj_res <= 10'h000;
      inj_res_ch <= 4'h0;
      o_mux_chan <= 4'h0;
      o_sample <= 1'b0;
      o_convert <= 1'b0;
      o_busy <= 1'b0;
      o_result_req <= 1'b0;
    end else begin
      o_result_req <= 1'b0;
      case (state)
        ST_IDLE: begin
          // with wait-for-read set, hold while the buffer is full unless an injection is pending
          if (run && (inj_go || fifo_wr_ready || !wfr)) begin
            is_inj <= inj_go;
            o_mux_chan <= inj_go ? inj_chan : cur_chan;
            state <= ST_SAMPLE;
            o_sample <= 1'b1;
            o_busy <= 1'b1;
            cnt <= tsc_cyc - 12'h001;
          end
        end
        ST_SAMPLE: begin
          if (cnt == 12'h000) begin
            state <= ST_CONVERT;
            o_sample <= 1'b0;
            o_convert <= 1'b1;
            cnt <= conv_cyc - 12'h001;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        ST_CONVERT: begin
          if (cnt == 12'h000) begin
            state <= ST_STORE;
            o_convert <= 1'b0;
            o_busy <= 1'b0;
            conv_val <= core_s2;
          end else begin
            cnt <= cnt - 12'h001;
          end
        end
        ST_STORE: begin
          state <= ST_IDLE;
          if (is_inj) begin
            inj_res <= conv_val;
            inj_res_ch <= o_mux_chan;
            inj_pend <= 1'b0;
          end else begin
            o_result_req <= fifo_wr_ready;
            case (ctl_mode)
              `ADCS_MODE_SINGLE: run <= 1'b0;
              `ADCS_MODE_SCAN: begin
                if (cur_chan == 4'h0) begin
                  run <= 1'b0;
                end else begin
                  cur_chan <= cur_chan - 4'h1;
                end
              end
              `ADCS_MODE_SCANC: begin
                if (cur_chan == 4'h0) begin
                  cur_chan <= ctl_chan;
                end else begin
                  cur_chan <= cur_chan - 4'h1;
                end
              end
              default: run <= run;
            endcase
          end
        end
        default: state <= ST_IDLE;
      endcase
      if (wr_cycle && (pend_addr == `ADCS_OFF_CTRL)) begin
        ctl_chan <= i_hwdata[`ADCS_CTRL_CHAN_LSB +: 4];
        ctl_mode <= i_hwdata[`ADCS_CTRL_MODE_LSB +: 2];
        wfr <= i_hwdata[`ADCS_CTRL_WFR_BIT];
        ssel <= i_hwdata[`ADCS_CTRL_SSEL_LSB +: 2];
        csel <= i_hwdata[`ADCS_CTRL_CSEL_LSB +: 2];
        inj_chan <= i_hwdata[`ADCS_CTRL_INJCH_LSB +: 4];
        run <= i_hwdata[`ADCS_CTRL_START_BIT];
        if (i_hwdata[`ADCS_CTRL_START_BIT] && !run) begin
          cur_chan <= i_hwdata[`ADCS_CTRL_CHAN_LSB +: 4];
        end
        if (i_hwdata[`ADCS_CTRL_INJ_BIT] && run && ctl_mode[0]) begin
          inj_pend <= 1'b1;
        end
      end
    end
  end
endmodule // adcs_top

// ### adcs_top_assertions.sv
// Port-level assertions of the ADC sequencer
`timescale 1ns/1ns
module adcs_chk (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Bus handshake
  input wire i_hsel,
  input wire [1:0] i_htrans,
  input wire i_hready,
  input wire o_hreadyout,
  input wire o_hresp,
  // Converter and requests
  input wire [3:0] o_mux_chan,
  input wire o_sample,
  input wire o_convert,
  input wire o_busy,
  input wire o_result_req,
  input wire o_overrun_req
);
  logic [11:0] s_cnt;
  logic [11:0] c_cnt;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Phase lengths in clocks
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_cnt <= 12'h000;
      c_cnt <= 12'h000;
    end else begin
      s_cnt <= o_sample ? s_cnt + 12'h001 : 12'h000;
      c_cnt <= o_convert ? c_cnt + 12'h001 : 12'h000;
    end
  end
  property p_busy; o_busy == (o_sample | o_convert); endproperty
  a_busy: assert property (p_busy) else $error("busy wrong");
  property p_slen;
    $fell(o_sample) |->
      s_cnt inside {12'h018, 12'h030, 12'h060, 12'h0C0, 12'h180, 12'h300};
  endproperty
  a_slen: assert property (p_slen) else $error("sample length");
  property p_clen;
    $fell(o_convert) |-> c_cnt inside {12'h0F0, 12'h1E0, 12'h3C0};
  endproperty
  a_clen: assert property (p_clen) else $error("convert length");
  property p_order; $rose(o_convert) |-> $past(o_sample) && !o_sample;
  endproperty
  a_order: assert property (p_order) else $error("no sample");
  property p_mux;
    (o_sample | o_convert) && ($past(o_sample) | $past(o_convert))
      |-> $stable(o_mux_chan);
  endproperty
  a_mux: assert property (p_mux) else $error("channel moved");
  property p_req;
    o_result_req |-> !o_overrun_req
      && ($past(o_convert, 2) || $past(o_convert, 3)) ##1 !o_result_req;
  endproperty
  a_req: assert property (p_req) else $error("result request");
  property p_ovr;
    o_overrun_req |-> ($past(o_convert, 2) || $past(o_convert, 3))
      ##1 !o_overrun_req;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun request");
  property p_bus;
    i_hsel && i_htrans[1] && i_hready |=>
      !o_hreadyout && !o_hresp ##1 o_hreadyout;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait state");
endmodule // adcs_chk

bind adcs_top adcs_chk u_adcs_chk (.i_clk, .i_resetn, .i_hsel, .i_htrans,
  .i_hready, .o_hreadyout, .o_hresp, .o_mux_chan, .o_sample, .o_convert,
  .o_busy, .o_result_req, .o_overrun_req);

// ### adcs_top_tb.sv
// Self-checking testbench of the ADC conversion sequencer
`timescale 1ns/1ns
module adcs_top_tb;
  logic i_clk;
  logic i_resetn;
  logic i_hsel;
  logic [31:0] i_haddr;
  logic [1:0] i_htrans;
  logic i_hwrite;
  logic [31:0] i_hwdata;
  logic [15:0] i_ain_digital;
  wire o_hreadyout;
  wire [31:0] o_hrdata;
  wire [3:0] o_mux_chan;
  wire o_sample;
  wire o_convert;
  wire [9:0] res;
  wire o_busy;
  wire o_result_req;
  wire o_overrun_req;
  int n_fail;
  int compares;
  logic [31:0] r;
  adcs_top u_adcs_top (.i_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize(3'b010), .i_hwdata, .i_hready(o_hreadyout),
    .o_hreadyout, .o_hresp(), .o_hrdata, .o_mux_chan, .o_sample,
    .o_convert, .i_core_result(res), .i_ain_digital, .o_busy,
    .o_result_req, .o_overrun_req);
  adcs_core_model u_adcs_core_model (.i_clk, .i_resetn,
    .i_mux_chan(o_mux_chan), .i_convert(o_convert), .o_result(res));
  always #10 i_clk = ~i_clk;
  function automatic logic [31:0] ev(input logic [3:0] c);
    ev = {15'h0000, 1'b1, c, 2'b00, c, 6'h15};
  endfunction
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_hsel <= 1'b1;
    i_htrans <= 2'b10;
    i_hwrite <= w;
    i_haddr <= {24'h000000, a};
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    i_htrans <= 2'b00;
    i_hsel <= 1'b0;
    i_hwdata <= d;
    do @(posedge i_clk); while (o_hreadyout !== 1'b1);
    r = o_hrdata;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rdc(input string n, input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    chk(n, r & m, e);
  endtask
  task wev(input logic o);
    int k;
    k = 0;
    do begin
      @(posedge i_clk);
      k++;
    end while ((o ? o_overrun_req : o_result_req) !== 1'b1 && k < 9000);
    chk("request", k < 9000, 32'h1);
  endtask
  task poll(input logic [7:0] a, input logic [31:0] m);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h00000000);
      k++;
    end while ((r & m) !== m && k < 3000);
    chk("poll", k < 3000, 32'h1);
  endtask
  task drain(input logic [3:0] c, input int n);
    repeat (n) rdc("result", 8'h04, 32'hFFFFFFFF, ev(c));
  endtask
  task t_rst;
    rdc("ctrl", 8'h00, 32'hFFFFFFFF, 32'h00000000);
    rdc("status", 8'h0C, 32'hFFFFFFFF, 32'h00000002);
    rdc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h00000000);
    i_ain_digital <= 16'hA5C3;
    repeat (4) @(posedge i_clk);
    rdc("digin", 8'h14, 32'hFFFFFFFF, 32'h0000A5C3);
  endtask
  task t_single;
    wr(8'h00, 32'h00000045);
    wev(1'b0);
    rdc("result", 8'h04, 32'hFFFFFFFF, ev(4'h5));
    repeat (600) @(posedge i_clk);
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00000002);
  endtask
  task t_scan;
    int i;
    wr(8'h00, 32'h00000063);
    repeat (4) wev(1'b0);
    for (i = 3; i >= 0; i--) begin
      rdc("result", 8'h04, 32'hFFFFFFFF, ev(i[3:0]));
    end
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00000002);
  endtask
  task t_clk;
    int cs;
    int ss;
    int tc;
    int k;
    int n;
    for (cs = 0; cs < 4; cs++) begin
      for (ss = 0; ss < 4; ss++) begin
        if (cs != 1) begin
          tc = cs == 0 ? 24 : cs == 2 ? 96 : 48;
          wr(8'h00, {18'h00000, cs[1:0], ss[1:0], 10'h040});
          k = 0;
          while (o_sample !== 1'b1 && k < 2000) begin
            @(posedge i_clk);
            k++;
          end
          n = 0;
          while (o_sample === 1'b1 && n < 9999) begin
            @(posedge i_clk);
            n++;
          end
          chk("sample", n, tc << ss);
          n = 0;
          while (o_convert === 1'b1 && n < 9999) begin
            @(posedge i_clk);
            n++;
          end
          chk("convert", n, tc * 10);
          wev(1'b0);
          rdc("result", 8'h04, 32'hFFFFFFFF, ev(4'h0));
        end
      end
    end
  endtask
  task t_wfr;
    int n;
    wr(8'h00, 32'h00000152);
    repeat (16) wev(1'b0);
    n = 0;
    repeat (400) begin
      @(posedge i_clk);
      n += (o_busy === 1'b1);
    end
    chk("busy", n, 32'h0);
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00001004);
    rdc("result", 8'h04, 32'hFFFFFFFF, ev(4'h2));
    wev(1'b0);
    wr(8'h00, 32'h00000000);
    drain(4'h2, 16);
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00000002);
  endtask
  task t_ovr;
    wr(8'h00, 32'h00000051);
    wev(1'b1);
    wr(8'h00, 32'h00000000);
    repeat (600) @(posedge i_clk);
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00001005);
    wr(8'h0C, 32'h00000001);
    rdc("status", 8'h0C, 32'h00001F0F, 32'h00001004);
    drain(4'h1, 16);
  endtask
  task t_inj;
    int i;
    wr(8'h00, 32'h00000072);
    wr(8'h00, 32'h00090272);
    poll(8'h08, 32'h00010000);
    chk("inject", r, ev(4'h9));
    poll(8'h0C, 32'h00000400);
    wr(8'h00, 32'h00000000);
    repeat (600) @(posedge i_clk);
    for (i = 0; i < 4; i++) begin
      rdc("result", 8'h04, 32'hFFFFFFFF, ev(4'(2 - i % 3)));
    end
  endtask
  task print_verdict;
    if (n_fail == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    i_resetn = 1'b0;
    i_hsel = 1'b0;
    i_haddr = 32'h00000000;
    i_htrans = 2'b00;
    i_hwrite = 1'b0;
    i_hwdata = 32'h00000000;
    i_ain_digital = 16'h0000;
    n_fail = 0;
    compares = 0;
    repeat (16) @(posedge i_clk);
    i_resetn <= 1'b1;
    @(posedge i_clk);
    t_rst;
    t_single;
    t_scan;
    t_clk;
    t_wfr;
    t_ovr;
    t_inj;
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge i_clk);
    n_fail++;
    print_verdict;
  end
endmodule // adcs_top_tb
